// file: hdl/fac_capture_core.sv
// Fault alert, parametric capture, capture store control and configuration stores.
// Assumes fault_event, ara_hit and the measurements come from logic on the same clock.
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
// What this block does
// - Pull the alert line low when any alert-enabled fault occurs.
// - Line stays low while faults pend; host repeats polling until all cleared.
// - Live input/output voltage, current, temperature, frequency, duty always readable.
// - Capture runs only while misc bit 1 is set.
// - Captured 22 bytes read as a block, allowed during normal operation.
// - Control value 1 copies flash set into RAM for immediate readout.
// - Control value 2 stores set to flash, only while output disabled.
// - Fault with shutdown response stores the set to flash automatically while capture (misc bit 1) is enabled.
// - Fault with retry response never triggers the automatic store.
// - Flash store takes 700 us block-arranged, 1400 us otherwise.
// - After reset, both stores are empty, so the init cycle loads the factory configuration.
// - Keep default and user stores; restore only to levels made available.
// - Protected default store allows default restore, refuses factory restore.
module fac_capture_core #(
	parameter int BLOCK_CYC = fac_pkg::STORE_BLOCK_CYC,
	parameter int BYTE_CYC  = fac_pkg::STORE_BYTE_CYC
) (
	// Clock and reset.
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// Register port.
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// Fault and bus events.
	input  wire logic [7:0]  fault_event,
	input  wire logic        ara_hit,
	input  wire logic        output_enabled,
	// Measurements.
	input  wire logic [15:0] meas_vin,
	input  wire logic [15:0] meas_vout,
	input  wire logic [15:0] meas_iout,
	input  wire logic [15:0] meas_temp,
	input  wire logic [15:0] meas_freq,
	input  wire logic [15:0] meas_duty,
	input  wire logic [79:0] aux_params,
	// Alert pin, interrupt and configuration word.
	output logic             fault_alert_line,
	output logic             fault_alert_line_oe,
	output logic             irq,
	output logic      [7:0]  cfg_word
);
	localparam int LAST = fac_pkg::CAP_BYTES - 1;

	fac_pkg::fac_state_t state_reg;
	logic [7:0]  misc_reg, mask_reg, irq_stat_reg, alert_en_reg, shut_en_reg, fault_reg;
	logic [7:0]  cfg_word_reg, user_store_reg, def_store_reg;
	logic        user_valid_reg, def_valid_reg, protect_reg;
	logic        alert_req_reg, ident_reg, freeze_reg;
	logic [4:0]  ptr_reg;
	logic [7:0]  cap_ram [fac_pkg::CAP_BYTES];
	logic [fac_pkg::CAP_BITS-1:0] live, cap_flat, flash_rd;
	logic        flash_busy, flash_done, flash_start;
	logic        wr_cap, rd_cap, cap_en, alert_new, alert_clear;
	logic        auto_req, save_cmd, save_ok, load_cmd, load_ok, cfg_cmd;
	logic [7:0]  irq_set, rd_next;

	assign live = {aux_params, meas_duty, meas_freq, meas_temp, meas_iout, meas_vout, meas_vin};
	assign cap_en = misc_reg[fac_pkg::MISC_CAP_EN];
	assign wr_cap = reg_wr && (reg_addr == fac_pkg::OFF_CAP_CTRL);
	assign rd_cap = reg_rd && (reg_addr == fac_pkg::OFF_CAP_DATA);
	assign cfg_cmd = reg_wr && (reg_addr == fac_pkg::OFF_CFG_CMD);

	// Command decode; a store only starts from idle with the program timer free.
	// shutdown fault store
	assign auto_req = cap_en && |(fault_event & shut_en_reg);
	assign save_cmd = wr_cap && (reg_wdata == fac_pkg::CAP_CMD_SAVE);
	assign save_ok = save_cmd && !output_enabled;
	assign load_cmd = wr_cap && (reg_wdata == fac_pkg::CAP_CMD_LOAD);
	assign load_ok = load_cmd && !flash_busy;
	assign flash_start = (auto_req || save_ok) && (state_reg == fac_pkg::FAC_IDLE) && !flash_busy;

	// Flatten the capture RAM for the flash write.
	for (genvar g = 0; g < fac_pkg::CAP_BYTES; g++) begin : g_flat
		assign cap_flat[g*8 +: 8] = cap_ram[g];
	end

	fac_flash_store #(
		.BLOCK_CYC (BLOCK_CYC),
		.BYTE_CYC  (BYTE_CYC)
	) u_store (
		.clock      (clock),
		.sys_rst    (sys_rst),
		.wr_start   (flash_start),
		.block_mode (misc_reg[fac_pkg::MISC_BLOCK]),
		.wr_data    (cap_flat),
		.rd_data    (flash_rd),
		.busy       (flash_busy),
		.done       (flash_done)
	);

	// Engine sequence: one init cycle loads the configuration, stores run to completion.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_reg <= fac_pkg::FAC_INIT;
		end else begin
			case (state_reg)
				fac_pkg::FAC_INIT:  state_reg <= fac_pkg::FAC_IDLE;
				fac_pkg::FAC_IDLE:  state_reg <= flash_start ? fac_pkg::FAC_STORE : fac_pkg::FAC_IDLE;
				fac_pkg::FAC_STORE: state_reg <= flash_done ? fac_pkg::FAC_IDLE : fac_pkg::FAC_STORE;
				default:            state_reg <= fac_pkg::FAC_INIT;
			endcase
		end
	end

	// Plain control registers.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			misc_reg     <= fac_pkg::MISC_RST;
			mask_reg     <= fac_pkg::MASK_RST;
			alert_en_reg <= fac_pkg::ALERT_EN_RST;
			shut_en_reg  <= fac_pkg::SHUT_EN_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				fac_pkg::OFF_MISC:     misc_reg <= reg_wdata;
				fac_pkg::OFF_IRQ_MASK: mask_reg <= reg_wdata;
				fac_pkg::OFF_ALERT_EN: alert_en_reg <= reg_wdata;
				fac_pkg::OFF_SHUT_EN:  shut_en_reg <= reg_wdata;
				default:               misc_reg <= misc_reg;
			endcase
		end
	end

	// Pending faults; a new fault in the clearing cycle survives the write-one clear.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			fault_reg <= 8'h00;
		end else if (reg_wr && reg_addr == fac_pkg::OFF_FAULT) begin
			fault_reg <= (fault_reg & ~reg_wdata) | fault_event;
		end else begin
			fault_reg <= fault_reg | fault_event;
		end
	end

	// Alert request and identification through the response address.
	assign alert_new = |(fault_event & alert_en_reg);
	assign alert_clear = ident_reg && !(|(fault_reg & alert_en_reg)) && !alert_new;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			alert_req_reg <= 1'b0;
			ident_reg     <= 1'b0;
		end else begin
			if (alert_new) begin
				alert_req_reg <= 1'b1;
				ident_reg     <= 1'b0;
			end else if (alert_clear) begin
				alert_req_reg <= 1'b0;
				ident_reg     <= 1'b0;
			end else if (ara_hit && alert_req_reg) begin
				ident_reg <= 1'b1;
			end
		end
	end
	assign fault_alert_line    = 1'b0;
	assign fault_alert_line_oe = alert_req_reg;

	// Capture RAM: tracks live data, frozen while a readout or a flash copy is held.
	// Cleared on reset so a readout before the first capture never shows unknown bytes.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			for (int i = 0; i < fac_pkg::CAP_BYTES; i++) begin
				cap_ram[i] <= 8'h00;
			end
		end else if (load_ok) begin
			for (int i = 0; i < fac_pkg::CAP_BYTES; i++) begin
				cap_ram[i] <= flash_rd[i*8 +: 8];
			end
		end else if (cap_en && !freeze_reg) begin
			for (int i = 0; i < fac_pkg::CAP_BYTES; i++) begin
				cap_ram[i] <= live[i*8 +: 8];
			end
		end
	end

	// Readout pointer; the freeze keeps a 22-byte block read coherent.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ptr_reg    <= 5'h00;
			freeze_reg <= 1'b0;
		end else if (load_ok || (reg_wr && reg_addr == fac_pkg::OFF_CAP_PTR)) begin
			ptr_reg    <= 5'h00;
			freeze_reg <= 1'b1;
		end else if (rd_cap) begin
			if (ptr_reg == 5'(LAST)) begin
				ptr_reg    <= 5'h00;
				freeze_reg <= 1'b0;
			end else begin
				ptr_reg    <= ptr_reg + 5'h01;
				freeze_reg <= 1'b1;
			end
		end
	end

	// Configuration stores, loaded once after reset and guarded on restore.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cfg_word_reg   <= fac_pkg::FACTORY_CFG;
			user_store_reg <= 8'h00;
			def_store_reg  <= 8'h00;
			user_valid_reg <= 1'b0;
			def_valid_reg  <= 1'b0;
			protect_reg    <= 1'b0;
		end else if (state_reg == fac_pkg::FAC_INIT) begin
			cfg_word_reg <= user_valid_reg ? user_store_reg :
				def_valid_reg ? def_store_reg : fac_pkg::FACTORY_CFG;
		end else if (reg_wr && reg_addr == fac_pkg::OFF_CFG_WORD) begin
			cfg_word_reg <= reg_wdata;
		end else if (reg_wr && reg_addr == fac_pkg::OFF_PROTECT) begin
			protect_reg <= protect_reg | reg_wdata[0];
		end else if (cfg_cmd) begin
			case (reg_wdata)
				fac_pkg::CFG_SAVE_USER: begin
					user_store_reg <= cfg_word_reg;
					user_valid_reg <= 1'b1;
				end
				fac_pkg::CFG_SAVE_DEF: begin
					def_store_reg <= protect_reg ? def_store_reg : cfg_word_reg;
					def_valid_reg <= def_valid_reg | !protect_reg;
				end
				fac_pkg::CFG_RESTORE_USER: begin
					cfg_word_reg <= user_valid_reg ? user_store_reg : cfg_word_reg;
				end
				fac_pkg::CFG_RESTORE_DEF: begin
					cfg_word_reg <= def_valid_reg ? def_store_reg : cfg_word_reg;
				end
				fac_pkg::CFG_RESTORE_FACT: begin
					cfg_word_reg <= protect_reg ? cfg_word_reg : fac_pkg::FACTORY_CFG;
				end
				default: cfg_word_reg <= cfg_word_reg;
			endcase
		end
	end
	assign cfg_word = cfg_word_reg;

	// Interrupt events.
	always_comb begin
		irq_set = 8'h00;
		irq_set[fac_pkg::IRQ_ALERT] = alert_new;
		irq_set[fac_pkg::IRQ_STORED] = flash_done;
		irq_set[fac_pkg::IRQ_STORE_REF] = ((auto_req || save_cmd) && !flash_start)
			|| (load_cmd && !load_ok);
		irq_set[fac_pkg::IRQ_RESTORED] = load_ok || (cfg_cmd && (
			(reg_wdata == fac_pkg::CFG_RESTORE_USER && user_valid_reg) ||
			(reg_wdata == fac_pkg::CFG_RESTORE_DEF && def_valid_reg) ||
			(reg_wdata == fac_pkg::CFG_RESTORE_FACT && !protect_reg)));
		irq_set[fac_pkg::IRQ_RESTORE_REF] = cfg_cmd && (
			(reg_wdata == fac_pkg::CFG_RESTORE_USER && !user_valid_reg) ||
			(reg_wdata == fac_pkg::CFG_RESTORE_DEF && !def_valid_reg) ||
			(reg_wdata == fac_pkg::CFG_RESTORE_FACT && protect_reg) ||
			(reg_wdata == fac_pkg::CFG_SAVE_DEF && protect_reg));
	end

	// Sticky status, write one to clear; a set in the same cycle wins.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			irq_stat_reg <= 8'h00;
		end else if (reg_wr && reg_addr == fac_pkg::OFF_IRQ_STAT) begin
			irq_stat_reg <= (irq_stat_reg & ~reg_wdata) | irq_set;
		end else begin
			irq_stat_reg <= irq_stat_reg | irq_set;
		end
	end
	assign irq = |(irq_stat_reg & mask_reg);

	// Read mux; unmapped addresses read zero.
	always_comb begin
		rd_next = 8'h00;
		case (reg_addr)
			fac_pkg::OFF_MISC:     rd_next = misc_reg;
			fac_pkg::OFF_IRQ_STAT: rd_next = irq_stat_reg;
			fac_pkg::OFF_IRQ_MASK: rd_next = mask_reg;
			fac_pkg::OFF_ALERT_EN: rd_next = alert_en_reg;
			fac_pkg::OFF_SHUT_EN:  rd_next = shut_en_reg;
			fac_pkg::OFF_FAULT:    rd_next = fault_reg;
			fac_pkg::OFF_CAP_DATA: rd_next = cap_ram[ptr_reg];
			fac_pkg::OFF_CAP_PTR:  rd_next = {3'h0, ptr_reg};
			fac_pkg::OFF_PROTECT:  rd_next = {7'h00, protect_reg};
			fac_pkg::OFF_STATUS:   rd_next = {1'b0, def_valid_reg, user_valid_reg, freeze_reg,
				flash_busy, ident_reg, alert_req_reg, state_reg == fac_pkg::FAC_IDLE};
			fac_pkg::OFF_CFG_WORD: rd_next = cfg_word_reg;
			default: begin
				if (reg_addr >= fac_pkg::OFF_LIVE
					&& reg_addr < fac_pkg::OFF_LIVE + 8'(fac_pkg::LIVE_BYTES)) begin
					rd_next = live[8*(reg_addr - fac_pkg::OFF_LIVE) +: 8];
				end
			end
		endcase
	end

	// Read data stands only in the cycle after the strobe.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? rd_next : 8'h00;
		end
	end

	// Helper: length of the running store, checked when it finishes.
	logic [15:0] busy_cnt;
	always_ff @(posedge clock) begin
		if (sys_rst || flash_start) begin
			busy_cnt <= 16'h0000;
		end else if (flash_busy) begin
			busy_cnt <= busy_cnt + 16'h0001;
		end
	end

	// A load, one quiet cycle, then the first readout strobe.
	sequence s_load_then_read;
		load_ok ##1 !rd_cap ##1 rd_cap;
	endsequence

	a_alert_drive: assert property (@(posedge clock) disable iff (sys_rst)
		alert_new |=> fault_alert_line_oe && !fault_alert_line)
		else $error("alert line not pulled after alerting fault");
	a_alert_hold: assert property (@(posedge clock) disable iff (sys_rst)
		fault_alert_line_oe && |(fault_reg & alert_en_reg) |=> fault_alert_line_oe)
		else $error("alert line released with faults pending");
	a_alert_release: assert property (@(posedge clock) disable iff (sys_rst)
		fault_alert_line_oe && alert_clear |=> !fault_alert_line_oe)
		else $error("alert line held after identification and clearing");
	a_cap_gate: assert property (@(posedge clock) disable iff (sys_rst)
		!cap_en && !load_ok |=> $stable(cap_ram[0]))
		else $error("capture RAM changed while capture disabled");
	a_load_readout: assert property (@(posedge clock) disable iff (sys_rst)
		s_load_then_read |=> reg_rdata == $past(flash_rd[7:0], 3))
		else $error("readout after flash copy returned wrong byte");
	a_block_wrap: assert property (@(posedge clock) disable iff (sys_rst)
		rd_cap && ptr_reg == 5'(LAST) && !load_ok |=> ptr_reg == 5'h00 && !freeze_reg)
		else $error("block read did not wrap after 22 bytes");
	a_save_refused: assert property (@(posedge clock) disable iff (sys_rst)
		save_cmd && output_enabled && !auto_req |-> !flash_start ##1
		irq_stat_reg[fac_pkg::IRQ_STORE_REF])
		else $error("store accepted while output enabled");
	a_auto_store: assert property (@(posedge clock) disable iff (sys_rst)
		auto_req && state_reg == fac_pkg::FAC_IDLE && !flash_busy |=> flash_busy [*2])
		else $error("shutdown fault did not start a flash store");
	a_retry_none: assert property (@(posedge clock) disable iff (sys_rst)
		!(|(fault_event & shut_en_reg)) && !save_ok |-> !flash_start)
		else $error("flash store started without shutdown fault or command");
	a_store_time: assert property (@(posedge clock) disable iff (sys_rst)
		flash_done |-> busy_cnt >= 16'(BLOCK_CYC) && busy_cnt <= 16'(BYTE_CYC))
		else $error("flash store length out of range");
	a_init_load: assert property (@(posedge clock) disable iff (sys_rst)
		state_reg == fac_pkg::FAC_INIT && !user_valid_reg && !def_valid_reg
		|=> state_reg == fac_pkg::FAC_IDLE && cfg_word_reg == fac_pkg::FACTORY_CFG)
		else $error("init did not load the factory configuration");
	a_fact_refused: assert property (@(posedge clock) disable iff (sys_rst)
		cfg_cmd && reg_wdata == fac_pkg::CFG_RESTORE_FACT && protect_reg
		|=> $stable(cfg_word_reg) && irq_stat_reg[fac_pkg::IRQ_RESTORE_REF])
		else $error("factory restore not refused while protected");

endmodule : fac_capture_core

// file: pkg/fac_pkg.sv
// Constants, register map and state encoding for the fault alert and capture store block.
// Assumes a single 20 MHz clock shared by the register port, fault inputs and measurement inputs.
package fac_pkg;

	// Capture set geometry: twelve bytes of live measurements plus ten auxiliary bytes.
	localparam int CAP_BYTES  = 22;
	localparam int LIVE_BYTES = 12;
	localparam int CAP_BITS   = CAP_BYTES * 8;

	// Register offsets on the plain register port.
	localparam logic [7:0] OFF_MISC     = 8'h00;
	localparam logic [7:0] OFF_CAP_CTRL = 8'h01;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h02;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h03;
	localparam logic [7:0] OFF_ALERT_EN = 8'h04;
	localparam logic [7:0] OFF_SHUT_EN  = 8'h05;
	localparam logic [7:0] OFF_FAULT    = 8'h06;
	localparam logic [7:0] OFF_CAP_DATA = 8'h07;
	localparam logic [7:0] OFF_CAP_PTR  = 8'h08;
	localparam logic [7:0] OFF_CFG_CMD  = 8'h09;
	localparam logic [7:0] OFF_PROTECT  = 8'h0a;
	localparam logic [7:0] OFF_STATUS   = 8'h0b;
	localparam logic [7:0] OFF_CFG_WORD = 8'h0c;
	localparam logic [7:0] OFF_LIVE     = 8'h10;

	// Field positions.
	localparam int MISC_CAP_EN = 1;
	localparam int MISC_BLOCK  = 2;
	localparam int IRQ_ALERT       = 0;
	localparam int IRQ_STORED      = 1;
	localparam int IRQ_STORE_REF   = 2;
	localparam int IRQ_RESTORED    = 3;
	localparam int IRQ_RESTORE_REF = 4;

	// Command codes.
	localparam logic [7:0] CAP_CMD_LOAD     = 8'h01;
	localparam logic [7:0] CAP_CMD_SAVE     = 8'h02;
	localparam logic [7:0] CFG_SAVE_USER    = 8'h01;
	localparam logic [7:0] CFG_SAVE_DEF     = 8'h02;
	localparam logic [7:0] CFG_RESTORE_USER = 8'h03;
	localparam logic [7:0] CFG_RESTORE_DEF  = 8'h04;
	localparam logic [7:0] CFG_RESTORE_FACT = 8'h05;

	// Values after reset.
	localparam logic [7:0] MISC_RST     = 8'h00;
	localparam logic [7:0] MASK_RST     = 8'h00;
	localparam logic [7:0] ALERT_EN_RST = 8'hff;
	localparam logic [7:0] SHUT_EN_RST  = 8'hff;
	localparam logic [7:0] FACTORY_CFG  = 8'h00;

	// Flash store time: block-arranged data is the short case.
	localparam int CLK_MHZ        = 20;
	localparam int STORE_BLOCK_US = 700;
	localparam int STORE_BYTE_US  = 1400;
	localparam int STORE_BLOCK_CYC = STORE_BLOCK_US * CLK_MHZ;
	localparam int STORE_BYTE_CYC  = STORE_BYTE_US * CLK_MHZ;

	// Engine states, Gray coded along init, idle, store.
	typedef enum logic [1:0] {
		FAC_INIT  = 2'b00,
		FAC_IDLE  = 2'b01,
		FAC_STORE = 2'b11
	} fac_state_t;

endpackage : fac_pkg

// file: hdl/fac_flash_store.sv
// Non-volatile capture store: holds one 22-byte set and models the timed program cycle.
// Assumes wr_start is a one-cycle pulse issued only while busy is low.
`timescale 1ns/10ps
module fac_flash_store #(
	parameter int BLOCK_CYC = fac_pkg::STORE_BLOCK_CYC,
	parameter int BYTE_CYC  = fac_pkg::STORE_BYTE_CYC
) (
	// Clock and reset.
	input  wire logic                        clock,
	input  wire logic                        sys_rst,
	// Program request.
	input  wire logic                        wr_start,
	input  wire logic                        block_mode,
	input  wire logic [fac_pkg::CAP_BITS-1:0] wr_data,
	// Stored data and progress.
	output logic      [fac_pkg::CAP_BITS-1:0] rd_data,
	output logic                             busy,
	output logic                             done
);
	logic [7:0]  mem [fac_pkg::CAP_BYTES];
	logic [15:0] cnt_reg;
	logic [15:0] target_reg;
	logic        busy_reg;
	logic        done_reg;

	// The array is the non-volatile cell, so reset leaves its contents alone.
	always_ff @(posedge clock) begin
		if (wr_start) begin
			for (int i = 0; i < fac_pkg::CAP_BYTES; i++) begin
				mem[i] <= wr_data[i*8 +: 8];
			end
		end
	end

	// Program timer; the length is chosen once per write from the data arrangement.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cnt_reg    <= 16'h0000;
			target_reg <= 16'h0000;
			busy_reg   <= 1'b0;
			done_reg   <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			if (wr_start && !busy_reg) begin
				busy_reg   <= 1'b1;
				cnt_reg    <= 16'h0001;
				target_reg <= block_mode ? 16'(BLOCK_CYC) : 16'(BYTE_CYC);
			end else if (busy_reg) begin
				if (cnt_reg == target_reg) begin
					busy_reg <= 1'b0;
					done_reg <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg + 16'h0001;
				end
			end
		end
	end

	// Flatten the array for the copy back to RAM.
	for (genvar g = 0; g < fac_pkg::CAP_BYTES; g++) begin : g_rd
		assign rd_data[g*8 +: 8] = mem[g];
	end

	assign busy = busy_reg;
	assign done = done_reg;

endmodule : fac_flash_store

// file: test/fac_host_model.sv
// Host model: answers a low alert line with Alert Response Address polls.
// Assumes the bench resolves the open-drain alert line with a pull-up.
`timescale 1ns/10ps
module fac_host_model (
	// Clock and reset.
	input  wire logic clock,
	input  wire logic sys_rst,
	// Shared alert line and poll result.
	input  wire logic alert_line,
	output logic      ara_hit
);
	logic [3:0] wait_cnt;

	// poll while low
	// Polls repeat every sixteen cycles, so a device still holding the line is asked again.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			wait_cnt <= 4'h0;
			ara_hit  <= 1'b0;
		end else begin
			ara_hit  <= (alert_line == 1'b0) && (wait_cnt == 4'h7);
			wait_cnt <= (alert_line == 1'b0) ? wait_cnt + 4'h1 : 4'h0;
		end
	end
endmodule : fac_host_model

// file: test/fac_capture_core_test.sv
// Self-checking bench for the fault alert and capture store core.
// Assumes short store lengths are enough to show both store durations.
`timescale 1ns/10ps
module fac_capture_core_test;
	localparam int BLK = 20;
	localparam int BYT = 40;
	logic         clock = 1'b0;
	logic         sys_rst = 1'b1;
	logic [7:0]   reg_addr = 8'h00;
	logic [7:0]   reg_wdata = 8'h00;
	logic         reg_wr = 1'b0;
	logic         reg_rd = 1'b0;
	logic [7:0]   reg_rdata;
	logic [7:0]   fault_event = 8'h00;
	logic         ara_hit;
	logic         output_enabled = 1'b1;
	logic [175:0] pat = '0;
	logic [175:0] saved;
	logic         line_o;
	logic         line_oe;
	logic         irq;
	logic [7:0]   cfg_word;
	logic [7:0]   rdv;
	int           fail_count = 0;
	int           n_tests = 0;
	// The alert line is open drain with a pull-up.
	wire          alert_line = line_oe ? line_o : 1'b1;

	always #25 clock = ~clock;

	fac_capture_core #(.BLOCK_CYC(BLK), .BYTE_CYC(BYT)) uut (
		.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fault_event(fault_event),
		.ara_hit(ara_hit), .output_enabled(output_enabled), .meas_vin(pat[15:0]),
		.meas_vout(pat[31:16]), .meas_iout(pat[47:32]), .meas_temp(pat[63:48]),
		.meas_freq(pat[79:64]), .meas_duty(pat[95:80]), .aux_params(pat[175:96]),
		.fault_alert_line(line_o), .fault_alert_line_oe(line_oe), .irq(irq),
		.cfg_word(cfg_word));

	fac_host_model host (.clock(clock), .sys_rst(sys_rst), .alert_line(alert_line),
		.ara_hit(ara_hit));

	task automatic wait_n(input int n);
		repeat (n) @(posedge clock);
	endtask : wait_n

	// One write cycle; the strobe drops after the edge that takes it.
	// The short wait lets the caller look at outputs that this edge updates.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		#1;
	endtask : wr

	// Read data stands only in the cycle after the strobe, so it is caught just then.
	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		rdv = reg_rdata;
	endtask : rd

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
		rd(a);
		chk(rdv & m, exp);
	endtask : rchk

	task automatic fault(input logic [7:0] v);
		@(posedge clock);
		fault_event <= v;
		@(posedge clock);
		fault_event <= 8'h00;
	endtask : fault

	// Byte i of the measurement set becomes b plus i.
	task automatic set_pat(input logic [7:0] b);
		logic [175:0] v;
		for (int i = 0; i < 22; i++) v[i*8 +: 8] = b + 8'(i);
		@(posedge clock);
		pat <= v;
	endtask : set_pat

	// Restart the readout pointer, then fetch the whole set.
	task automatic cap_chk(input logic [175:0] e);
		wr(fac_pkg::OFF_CAP_PTR, 8'h00);
		for (int i = 0; i < 22; i++) rchk(fac_pkg::OFF_CAP_DATA, 8'hff, e[i*8 +: 8]);
	endtask : cap_chk

	task automatic print_verdict();
		if (fail_count == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : print_verdict

	// Watchdog: the sequence needs well under a thousand cycles.
	initial begin
		wait_n(5000);
		fail_count++;
		print_verdict();
	end

	// Main sequence.
	initial begin
		wait_n(12);
		sys_rst <= 1'b0;
		wait_n(2);
		chk(cfg_word, fac_pkg::FACTORY_CFG);
		rchk(fac_pkg::OFF_ALERT_EN, 8'hff, fac_pkg::ALERT_EN_RST);
		rchk(fac_pkg::OFF_SHUT_EN, 8'hff, fac_pkg::SHUT_EN_RST);
		rchk(fac_pkg::OFF_MISC, 8'hff, fac_pkg::MISC_RST);
		rchk(8'hff, 8'hff, 8'h00);
		// A source left out of the alert mask must not pull the line.
		wr(fac_pkg::OFF_ALERT_EN, 8'hfe);
		fault(8'h01);
		wait_n(2);
		chk({7'h00, alert_line}, 8'h01);
		fault(8'h02);
		wait_n(40);
		chk({7'h00, alert_line}, 8'h00);
		rchk(fac_pkg::OFF_STATUS, 8'h06, 8'h06);
		chk({7'h00, irq}, 8'h00);
		wr(fac_pkg::OFF_IRQ_MASK, 8'h01);
		chk({7'h00, irq}, 8'h01);
		wr(fac_pkg::OFF_IRQ_STAT, 8'h01);
		chk({7'h00, irq}, 8'h00);
		wr(fac_pkg::OFF_FAULT, 8'hff);
		wait_n(20);
		chk({7'h00, alert_line}, 8'h01);
		set_pat(8'h10);
		for (int i = 0; i < 12; i++) rchk(fac_pkg::OFF_LIVE + 8'(i), 8'hff, 8'h10 + 8'(i));
		// Shutdown fault with capture off, then a retry fault with capture on.
		fault(8'h04);
		rchk(fac_pkg::OFF_STATUS, 8'h08, 8'h00);
		wr(fac_pkg::OFF_MISC, 8'h06);
		wr(fac_pkg::OFF_SHUT_EN, 8'hfe);
		set_pat(8'h40);
		fault(8'h01);
		rchk(fac_pkg::OFF_STATUS, 8'h08, 8'h00);
		fault(8'h02);
		wait_n(BLK - 6);
		rchk(fac_pkg::OFF_STATUS, 8'h08, 8'h08);
		wait_n(8);
		rchk(fac_pkg::OFF_STATUS, 8'h08, 8'h00);
		rchk(fac_pkg::OFF_IRQ_STAT, 8'h02, 8'h02);
		wr(fac_pkg::OFF_IRQ_STAT, 8'hff);
		// Manual store: refused with the output on, byte-arranged length otherwise.
		wr(fac_pkg::OFF_MISC, 8'h02);
		wr(fac_pkg::OFF_CAP_CTRL, fac_pkg::CAP_CMD_SAVE);
		rchk(fac_pkg::OFF_IRQ_STAT, 8'h06, 8'h04);
		@(posedge clock);
		output_enabled <= 1'b0;
		set_pat(8'h80);
		saved = {22{8'h00}};
		for (int i = 0; i < 22; i++) saved[i*8 +: 8] = 8'h80 + 8'(i);
		wr(fac_pkg::OFF_CAP_CTRL, fac_pkg::CAP_CMD_SAVE);
		wait_n(BYT - 6);
		rchk(fac_pkg::OFF_STATUS, 8'h08, 8'h08);
		wait_n(8);
		rchk(fac_pkg::OFF_IRQ_STAT, 8'h02, 8'h02);
		// Load the flash copy over a differing live set, then read live capture.
		@(posedge clock);
		output_enabled <= 1'b1;
		set_pat(8'hc0);
		wr(fac_pkg::OFF_CAP_CTRL, fac_pkg::CAP_CMD_LOAD);
		rchk(fac_pkg::OFF_CAP_DATA, 8'hff, saved[7:0]);
		cap_chk(saved);
		set_pat(8'h20);
		wait_n(2);
		cap_chk(pat);
		// Configuration stores and protection.
		wr(fac_pkg::OFF_CFG_WORD, 8'h5a);
		wr(fac_pkg::OFF_CFG_CMD, fac_pkg::CFG_SAVE_DEF);
		wr(fac_pkg::OFF_CFG_WORD, 8'h11);
		wr(fac_pkg::OFF_CFG_CMD, fac_pkg::CFG_SAVE_USER);
		wr(fac_pkg::OFF_CFG_WORD, 8'h00);
		wr(fac_pkg::OFF_CFG_CMD, fac_pkg::CFG_RESTORE_USER);
		wait_n(2);
		chk(cfg_word, 8'h11);
		wr(fac_pkg::OFF_PROTECT, 8'h01);
		wr(fac_pkg::OFF_CFG_WORD, 8'h77);
		wr(fac_pkg::OFF_CFG_CMD, fac_pkg::CFG_RESTORE_FACT);
		wait_n(2);
		chk(cfg_word, 8'h77);
		rchk(fac_pkg::OFF_IRQ_STAT, 8'h10, 8'h10);
		wr(fac_pkg::OFF_IRQ_STAT, 8'h08);
		wr(fac_pkg::OFF_CFG_CMD, fac_pkg::CFG_RESTORE_DEF);
		wait_n(2);
		chk(cfg_word, 8'h5a);
		rchk(fac_pkg::OFF_IRQ_STAT, 8'h08, 8'h08);
		print_verdict();
	end
endmodule : fac_capture_core_test
